// >>> cbrf_pkg.sv
// cbrf_pkg: constants and types of the banked cpu register file
// assumes one clock (pclk) and an apb slave port on the top module
// Operation
// - thirteen registers, seven duplicated into two banks
// - four 16-bit data regs, first two byte-split
// - data pairs form 32-bit operands, higher upper
// - address regs act as data, pair 32-bit
// - 16-bit frame base for frame-relative addressing
// - 20-bit program counter holds next instruction
// - 20-bit vector table base address
// - user/interrupt stack pointers, chosen by bit 7
// - 16-bit static base register
// - bit 0 captures alu carry or shift-out
// - bit 1 raises single-step; acknowledge clears it
// - bit 2 set on zero result
// - bit 3 set on negative result
// - bit 4 selects the register bank
// - bit 5 set on overflow
// - bit 6 gates maskable interrupts; ack clears
// - bit 7 cleared on hw ack, swi 0-31
// - bits 12-14 priority level; accept strictly above
// - bits 8-11 and 15 are reserved
package cbrf_pkg;

	// flag word bit positions
	localparam int PFW_C = 0;
	localparam int PFW_D = 1;
	localparam int PFW_Z = 2;
	localparam int PFW_S = 3;
	localparam int PFW_B = 4;
	localparam int PFW_O = 5;
	localparam int PFW_I = 6;
	localparam int PFW_U = 7;
	localparam int PFW_PRI_LSB = 12;
	localparam int PFW_PRI_MSB = 14;

	// writable flag bits; reserved positions masked off
	localparam logic [15:0] PFW_WMASK = 16'h70ff;

	// reset values
	localparam logic [15:0] PFW_RESET = 16'h0000;
	localparam logic [15:0] REG16_RESET = 16'h0000;
	localparam logic [19:0] REG20_RESET = 20'h00000;

	// banked register slots inside one bank
	localparam int BANK_REGS = 7;
	// slots fed from the upper half of a 32-bit write (2, 3, 5)
	localparam logic [6:0] BANK_HI_LANE = 7'h2c;
	localparam logic [6:0] BK_DR0 = 7'h01;
	localparam logic [6:0] BK_DR1 = 7'h02;
	localparam logic [6:0] BK_DR2 = 7'h04;
	localparam logic [6:0] BK_DR3 = 7'h08;
	localparam logic [6:0] BK_AR0 = 7'h10;
	localparam logic [6:0] BK_AR1 = 7'h20;
	localparam logic [6:0] BK_FBR = 7'h40;

	// software interrupts below this number drop to the irq stack
	localparam logic [5:0] SWI_U_LIMIT = 6'h20;

	// apb: one aligned word per selector, byte address = index * 4
	localparam int APB_AW = 12;
	localparam logic [4:0] SEL_NUM = 5'h15;

	// register selectors shared by the datapath ports and apb map
	typedef enum logic [4:0] {
		SEL_DR0, SEL_DR1, SEL_DR2, SEL_DR3,
		SEL_DR0_LO, SEL_DR0_HI, SEL_DR1_LO, SEL_DR1_HI,
		SEL_AR0, SEL_AR1, SEL_FBR, SEL_SBR,
		SEL_USPTR, SEL_ISPTR, SEL_SP, SEL_VTB,
		SEL_PC, SEL_FLAGS, SEL_WD_LO, SEL_WD_HI, SEL_WA
	} cbrf_sel_t;

	// operand size of an alu result
	typedef enum logic [1:0] {
		SZ_BYTE, SZ_WORD, SZ_LONG
	} cbrf_size_t;

endpackage : cbrf_pkg

// >>> cbrf_bank_if.sv
// cbrf_bank_if: write request and read-back of one register bank
// assumes the top module drives the write side in its own clock
`timescale 1ns/1ps
interface cbrf_bank_if;
	logic [6:0]       wmask; // one bit per banked slot
	logic [1:0]       be;    // byte lanes
	logic [15:0]      wlo;   // data for low-lane slots
	logic [15:0]      whi;   // data for high-lane slots
	logic [6:0][15:0] rd;    // registered contents

	modport ctrl (output wmask, output be, output wlo, output whi,
		input rd);
	modport bank (input wmask, input be, input wlo, input whi,
		output rd);
endinterface : cbrf_bank_if

// >>> cbrf_bank.sv
// cbrf_bank: one bank of data, address and frame base registers
// assumes at most one write request per cycle from the top module
`timescale 1ns/1ps
module cbrf_bank
	import cbrf_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// write request and read-back
	cbrf_bank_if.bank bif
);

	typedef struct packed {
		logic [6:0][15:0] r;
	} cbrf_bank_st_t;

	cbrf_bank_st_t q;
	cbrf_bank_st_t d;

	// byte-lane write; pair writes hit two slots at once
	always_comb begin
		logic [15:0] lane;
		lane = REG16_RESET;
		d = q;
		for (int i = 0; i < BANK_REGS; i++) begin
			lane = BANK_HI_LANE[i] ? bif.whi : bif.wlo;
			if (bif.wmask[i] && bif.be[0]) begin
				d.r[i][7:0] = lane[7:0];
			end
			if (bif.wmask[i] && bif.be[1]) begin
				d.r[i][15:8] = lane[15:8];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign bif.rd = q.r;

endmodule : cbrf_bank

// >>> cbrf_regfile.sv
// cbrf_regfile: programmer-visible register set of a 16-bit core
// assumes datapath ports synchronous to pclk; apb for debug access
`timescale 1ns/1ps
module cbrf_regfile
	import cbrf_pkg::*;
(
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [APB_AW-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// datapath read port
	input  wire cbrf_sel_t         rd_sel,
	output logic [31:0]            rd_data,
	// datapath write port
	input  wire logic              wr_en,
	input  wire cbrf_sel_t         wr_sel,
	input  wire logic [31:0]       wr_data,
	// alu flag update
	input  wire logic              alu_upd,
	input  wire cbrf_size_t        alu_size,
	input  wire logic [31:0]       alu_res,
	input  wire logic              alu_c,
	input  wire logic              alu_o,
	// interrupt and sequencing events
	input  wire logic              instr_done,
	input  wire logic              irq_req,
	input  wire logic [2:0]        irq_prio,
	input  wire logic              irq_maskable,
	input  wire logic              irq_ack,
	input  wire logic              step_ack,
	input  wire logic              swi_exec,
	input  wire logic [5:0]        swi_num,
	// state seen by the core
	output logic [15:0]            flag_word,
	output logic [19:0]            pc,
	output logic                   irq_accept,
	output logic                   step_irq
);

	typedef struct packed {
		logic [19:0] pc;
		logic [19:0] vtb;
		logic [15:0] sbr;
		// stack pointers, user and interrupt
		logic [15:0] usr_sp;
		logic [15:0] irq_sp;
		logic [15:0] fw;
		logic [31:0] rd_data;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        irq_accept;
		logic        step_irq;
	} cbrf_st_t;

	cbrf_st_t q;
	cbrf_st_t d;

	cbrf_bank_if bif0 ();
	cbrf_bank_if bif1 ();

	logic [6:0][15:0] bank_rd;
	logic [6:0]       wmask;
	logic [1:0]       wbe;
	logic [15:0]      wlo;
	logic [15:0]      whi;
	logic             apb_take;
	logic             apb_ok;
	cbrf_sel_t        apb_sel;
	logic             src_en;
	cbrf_sel_t        src_sel;
	logic [31:0]      src_data;
	logic [15:0]      res_lo;

	// two identical banks of seven registers each
	cbrf_bank u_bank0 (
		.pclk    (pclk),
		.presetn (presetn),
		.bif     (bif0)
	);
	cbrf_bank u_bank1 (
		.pclk    (pclk),
		.presetn (presetn),
		.bif     (bif1)
	);

	// active bank picked by the bank flag
	// both banks keep their contents; only the view switches
	assign bank_rd = q.fw[PFW_B] ? bif1.rd : bif0.rd;

	// route the write request to the active bank only
	// the idle bank sees no request and holds its contents
	assign bif0.wmask = q.fw[PFW_B] ? 7'h00 : wmask;
	assign bif1.wmask = q.fw[PFW_B] ? wmask : 7'h00;
	assign bif0.be    = wbe;
	assign bif1.be    = wbe;
	assign bif0.wlo   = wlo;
	assign bif1.wlo   = wlo;
	assign bif0.whi   = whi;
	assign bif1.whi   = whi;

	// read multiplexer shared by datapath and apb
	function automatic logic [31:0] rd_val(
		input cbrf_sel_t        s,
		input cbrf_st_t         st,
		input logic [6:0][15:0] b
	);
		logic [31:0] v;
		v = '0;
		unique case (s)
			SEL_DR0:    v[15:0] = b[0];
			SEL_DR1:    v[15:0] = b[1];
			SEL_DR2:    v[15:0] = b[2];
			SEL_DR3:    v[15:0] = b[3];
			SEL_DR0_LO: v[7:0]  = b[0][7:0];
			SEL_DR0_HI: v[7:0]  = b[0][15:8];
			SEL_DR1_LO: v[7:0]  = b[1][7:0];
			SEL_DR1_HI: v[7:0]  = b[1][15:8];
			SEL_AR0:    v[15:0] = b[4];
			SEL_AR1:    v[15:0] = b[5];
			SEL_FBR:    v[15:0] = b[6];
			SEL_SBR:    v[15:0] = st.sbr;
			// both pointers stay reachable by name for the debugger
			SEL_USPTR:  v[15:0] = st.usr_sp;
			SEL_ISPTR:  v[15:0] = st.irq_sp;
			SEL_SP: begin
				// user pointer when set, interrupt pointer when clear
				v[15:0] = st.fw[PFW_U] ? st.usr_sp : st.irq_sp;
			end
			SEL_VTB:    v[19:0] = st.vtb;
			SEL_PC:     v[19:0] = st.pc;
			SEL_FLAGS:  v[15:0] = st.fw & PFW_WMASK;
			SEL_WD_LO:  v = {b[2], b[0]};
			SEL_WD_HI:  v = {b[3], b[1]};
			SEL_WA:     v = {b[5], b[4]};
			default:    v = '0;
		endcase
		return v;
	endfunction : rd_val

	// apb decode: word aligned, inside the selector range
	assign apb_sel = cbrf_sel_t'(paddr[6:2]);
	assign apb_ok  = (paddr[APB_AW-1:7] == '0) &&
		(paddr[1:0] == 2'h0) && (paddr[6:2] < SEL_NUM);

	// one wait state; the datapath write port has priority, so
	// the bus stalls while the core writes
	assign apb_take = psel && penable && !q.pready && !wr_en;

	// single write source per cycle keeps one bank request
	assign src_en   = wr_en || (apb_take && pwrite && apb_ok);
	assign src_sel  = wr_en ? wr_sel : apb_sel;
	assign src_data = wr_en ? wr_data : pwdata;

	// bank write request for the selected target
	always_comb begin
		wmask = 7'h00;
		wbe   = 2'h3;
		wlo   = src_data[15:0];
		whi   = src_data[15:0];
		if (src_en) begin
			unique case (src_sel)
				SEL_DR0: wmask = BK_DR0;
				SEL_DR1: wmask = BK_DR1;
				SEL_DR2: wmask = BK_DR2;
				SEL_DR3: wmask = BK_DR3;
				SEL_DR0_LO, SEL_DR0_HI,
				SEL_DR1_LO, SEL_DR1_HI: begin
					// byte copied to both lanes, enable picks one
					wmask = (src_sel == SEL_DR0_LO ||
						src_sel == SEL_DR0_HI) ? BK_DR0 : BK_DR1;
					wbe = (src_sel == SEL_DR0_HI ||
						src_sel == SEL_DR1_HI) ? 2'h2 : 2'h1;
					wlo = {src_data[7:0], src_data[7:0]};
				end
				SEL_AR0: wmask = BK_AR0;
				SEL_AR1: wmask = BK_AR1;
				SEL_FBR: wmask = BK_FBR;
				SEL_WD_LO: begin
					wmask = BK_DR0 | BK_DR2;
					whi   = src_data[31:16];
				end
				SEL_WD_HI: begin
					wmask = BK_DR1 | BK_DR3;
					whi   = src_data[31:16];
				end
				SEL_WA: begin
					wmask = BK_AR0 | BK_AR1;
					whi   = src_data[31:16];
				end
				default: wmask = 7'h00;
			endcase
		end
	end

	// sized alu result for zero and sign
	always_comb begin
		res_lo = alu_res[15:0];
		if (alu_size == SZ_BYTE) begin
			res_lo = {8'h00, alu_res[7:0]};
		end
	end

	// next state: unbanked writes, flags, interrupts, apb answer
	always_comb begin
		logic       z_nx;
		logic       s_nx;
		logic [2:0] lvl;
		z_nx = 1'b0;
		s_nx = 1'b0;
		lvl  = 3'h0;
		d = q;

		// unbanked registers from the single write source
		if (src_en) begin
			unique case (src_sel)
				SEL_SBR:   d.sbr = src_data[15:0];
				SEL_USPTR: d.usr_sp = src_data[15:0];
				SEL_ISPTR: d.irq_sp = src_data[15:0];
				SEL_SP: begin
					// writes follow the same select as the read
					if (q.fw[PFW_U]) begin
						d.usr_sp = src_data[15:0];
					end else begin
						d.irq_sp = src_data[15:0];
					end
				end
				SEL_VTB: d.vtb = src_data[19:0];
				SEL_PC:  d.pc  = src_data[19:0];
				SEL_FLAGS: begin
					d.fw = src_data[15:0] & PFW_WMASK;
				end
				default: d.pc = q.pc;
			endcase
		end

		// alu condition flags follow the result
		if (alu_upd) begin
			unique case (alu_size)
				SZ_BYTE: begin
					z_nx = (res_lo[7:0] == 8'h00);
					s_nx = res_lo[7];
				end
				SZ_WORD: begin
					z_nx = (res_lo == 16'h0000);
					s_nx = res_lo[15];
				end
				SZ_LONG: begin
					z_nx = (alu_res == 32'h00000000);
					s_nx = alu_res[31];
				end
				default: begin
					z_nx = 1'b0;
					s_nx = 1'b0;
				end
			endcase
			// carry and overflow come ready-made from the alu
			d.fw[PFW_C] = alu_c;
			d.fw[PFW_Z] = z_nx;
			d.fw[PFW_S] = s_nx;
			d.fw[PFW_O] = alu_o;
		end

		// acknowledges override a same-cycle write of the flags
		// step ack touches only the step flag
		if (step_ack) begin
			d.fw[PFW_D] = 1'b0;
		end
		// irq ack leaves the step flag alone
		if (irq_ack) begin
			d.fw[PFW_I] = 1'b0;
			d.fw[PFW_U] = 1'b0;
		end
		// swi 32 and up keep the current stack
		if (swi_exec && swi_num < SWI_U_LIMIT) begin
			d.fw[PFW_U] = 1'b0;
		end
		// reserved bits never hold a one
		d.fw = d.fw & PFW_WMASK;

		// single-step request: a new step wins over its ack
		d.step_irq = (instr_done && q.fw[PFW_D]) ||
			(q.step_irq && !step_ack);

		// acceptance: maskable ones need the enable flag
		// strict compare: equal priority is refused
		lvl = q.fw[PFW_PRI_MSB:PFW_PRI_LSB];
		// not latched; the core decides when to take it
		d.irq_accept = irq_req &&
			(!irq_maskable || q.fw[PFW_I]) &&
			(irq_prio > lvl);

		// registered datapath read
		d.rd_data = rd_val(rd_sel, q, bank_rd);

		// apb answer, one cycle of pready
		d.pready = apb_take;
		if (apb_take) begin
			d.pslverr = !apb_ok;
			d.prdata  = (apb_ok && !pwrite) ?
				rd_val(apb_sel, q, bank_rd) : 32'h00000000;
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q.pc         <= REG20_RESET;
			q.vtb        <= REG20_RESET;
			q.sbr        <= REG16_RESET;
			q.usr_sp     <= REG16_RESET;
			q.irq_sp     <= REG16_RESET;
			// bank registers clear inside their own modules
			q.fw         <= PFW_RESET;
			q.rd_data    <= 32'h00000000;
			q.prdata     <= 32'h00000000;
			q.pready     <= 1'b0;
			q.pslverr    <= 1'b0;
			q.irq_accept <= 1'b0;
			q.step_irq   <= 1'b0;
		end else begin
			q <= d;
		end
	end

	// outputs straight from the state register
	assign prdata     = q.prdata;
	assign pready     = q.pready;
	assign pslverr    = q.pslverr;
	assign rd_data    = q.rd_data;
	assign flag_word  = q.fw; // reserved bits already masked
	assign pc         = q.pc;
	assign irq_accept = q.irq_accept;
	assign step_irq   = q.step_irq;

endmodule : cbrf_regfile

// >>> cbrf_checker.sv
// cbrf_checker: concurrent checks on flag, interrupt and apb outputs
// assumes it is bound into cbrf_regfile and sees its ports only
`timescale 1ns/1ps
module cbrf_checker
	import cbrf_pkg::*;
(
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb handshake
	input wire logic        pready,
	// alu flag update
	input wire logic        alu_upd,
	input wire cbrf_size_t  alu_size,
	input wire logic [31:0] alu_res,
	input wire logic        alu_c,
	input wire logic        alu_o,
	// interrupt and sequencing events
	input wire logic        instr_done,
	input wire logic        irq_req,
	input wire logic [2:0]  irq_prio,
	input wire logic        irq_maskable,
	input wire logic        irq_ack,
	input wire logic        step_ack,
	input wire logic        swi_exec,
	input wire logic [5:0]  swi_num,
	// state seen by the core
	input wire logic [15:0] flag_word,
	input wire logic        irq_accept,
	input wire logic        step_irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic [31:0] res_q;
	logic        acc_d;

	// result one cycle back, so the flags can be judged a cycle late
	always_ff @(posedge pclk) begin
		res_q <= alu_res;
	end

	// acceptance as it should be decided from the current inputs
	assign acc_d = irq_req && (!irq_maskable || flag_word[6]) &&
		irq_prio > flag_word[14:12];

	chk_resv_zero: assert property (
		flag_word[11:8] == 4'h0 && !flag_word[15])
		else $error("reserved flag bit seen set");
	chk_word_flags: assert property (
		alu_upd && alu_size == SZ_WORD |=> flag_word[2] ==
		(res_q[15:0] == 16'h0) && flag_word[3] == res_q[15] &&
		flag_word[0] == $past(alu_c) && flag_word[5] == $past(alu_o))
		else $error("word alu flags wrong");
	chk_irq_accept: assert property (
		1'b1 |=> irq_accept == $past(acc_d))
		else $error("interrupt acceptance wrong");
	chk_step_raise: assert property (
		instr_done && flag_word[1] |=> step_irq)
		else $error("single step not raised");
	chk_step_clear: assert property (
		step_ack && !instr_done |=> !step_irq && !flag_word[1])
		else $error("step ack did not clear");
	chk_ack_clear: assert property (
		irq_ack |=> !flag_word[6] && !flag_word[7])
		else $error("irq ack did not clear enable and stack");
	chk_swi_user: assert property (
		swi_exec && swi_num < 6'h20 |=> !flag_word[7])
		else $error("low swi kept user stack");
	chk_ready_pulse: assert property (
		pready |=> !pready)
		else $error("pready longer than one cycle");
endmodule : cbrf_checker

bind cbrf_regfile cbrf_checker u_chk (
	.pclk(pclk), .presetn(presetn), .pready(pready),
	.alu_upd(alu_upd), .alu_size(alu_size), .alu_res(alu_res),
	.alu_c(alu_c), .alu_o(alu_o), .instr_done(instr_done),
	.irq_req(irq_req), .irq_prio(irq_prio), .irq_maskable(irq_maskable),
	.irq_ack(irq_ack), .step_ack(step_ack), .swi_exec(swi_exec),
	.swi_num(swi_num), .flag_word(flag_word), .irq_accept(irq_accept),
	.step_irq(step_irq)
);

// >>> cbrf_regfile_test.sv
// cbrf_regfile_test: directed bench for the banked register file
// assumes the checker is bound in from its own file
`timescale 1ns/1ps
module cbrf_regfile_test
	import cbrf_pkg::*;
;
	logic        pclk = 1'b0, presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, wr_data = 32'h0, alu_res = 32'h0;
	logic [31:0] prdata, rd_data, rdat;
	logic        pready, pslverr, irq_accept, step_irq, rerr;
	logic        wr_en = 1'b0, alu_upd = 1'b0, alu_c = 1'b0, alu_o = 1'b0;
	logic        instr_done = 1'b0, irq_req = 1'b0, irq_maskable = 1'b0;
	logic        irq_ack = 1'b0, step_ack = 1'b0, swi_exec = 1'b0;
	logic [2:0]  irq_prio = 3'h0;
	logic [5:0]  swi_num = 6'h0;
	logic [15:0] flag_word;
	logic [19:0] pc;
	cbrf_sel_t   rd_sel = SEL_DR0, wr_sel = SEL_DR0;
	cbrf_size_t  alu_size = SZ_BYTE;
	int          error_cnt = 0, n_tests = 0;

	cbrf_regfile uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rd_sel(rd_sel),
		.rd_data(rd_data), .wr_en(wr_en), .wr_sel(wr_sel),
		.wr_data(wr_data), .alu_upd(alu_upd), .alu_size(alu_size),
		.alu_res(alu_res), .alu_c(alu_c), .alu_o(alu_o),
		.instr_done(instr_done), .irq_req(irq_req), .irq_prio(irq_prio),
		.irq_maskable(irq_maskable), .irq_ack(irq_ack),
		.step_ack(step_ack), .swi_exec(swi_exec), .swi_num(swi_num),
		.flag_word(flag_word), .pc(pc), .irq_accept(irq_accept),
		.step_irq(step_irq)
	);

	// 50 mhz clock
	always #10 pclk = ~pclk;

	task summarize;
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize

	task chk(input string nm, input logic [31:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// one apb transfer; request held until pready is seen at an edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (!pready && n < 20);
		if (!pready) begin
			error_cnt++;
			summarize();
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task sf(input logic [15:0] v);
		apb(1'b1, 12'h044, {16'h0, v});
	endtask : sf

	task fchk(input logic [15:0] e);
		@(negedge pclk);
		chk("flag_word", {16'h0, flag_word}, {16'h0, e});
	endtask : fchk

	task wr(input cbrf_sel_t s, input logic [31:0] d);
		@(posedge pclk);
		wr_sel <= s;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge pclk);
		wr_en <= 1'b0;
	endtask : wr

	// read port answers one edge after the selector is taken
	task rd(input cbrf_sel_t s, input logic [31:0] e);
		@(posedge pclk);
		rd_sel <= s;
		@(posedge pclk);
		@(negedge pclk);
		chk("rd_data", rd_data, e);
	endtask : rd

	task alu(input cbrf_size_t z, input logic [31:0] r,
		input logic c, o, input logic [15:0] e);
		@(posedge pclk);
		alu_upd <= 1'b1;
		alu_size <= z;
		alu_res <= r;
		alu_c <= c;
		alu_o <= o;
		@(posedge pclk);
		alu_upd <= 1'b0;
		fchk(e);
	endtask : alu

	task acc(input logic m, input logic [2:0] p, input logic e);
		@(posedge pclk);
		irq_req <= 1'b1;
		irq_maskable <= m;
		irq_prio <= p;
		@(posedge pclk);
		@(negedge pclk);
		chk("irq_accept", {31'h0, irq_accept}, {31'h0, e});
	endtask : acc

	task swi(input logic [5:0] n, input logic [15:0] e);
		@(posedge pclk);
		irq_req <= 1'b0;
		swi_exec <= 1'b1;
		swi_num <= n;
		@(posedge pclk);
		swi_exec <= 1'b0;
		fchk(e);
	endtask : swi

	// main sequence
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		fchk(16'h0000);
		sf(16'hffff);
		apb(1'b0, 12'h044, 32'h0);
		chk("flag_rd", rdat, 32'h70ff);
		chk("pslverr", {31'h0, rerr}, 32'h0);
		wr(SEL_DR0, 32'h1111);
		sf(16'h0000);
		rd(SEL_DR0, 32'h0);
		sf(16'h0010);
		rd(SEL_DR0, 32'h1111);
		wr(SEL_WD_LO, 32'haaaa5555);
		rd(SEL_DR2, 32'haaaa);
		rd(SEL_DR0, 32'h5555);
		wr(SEL_WD_HI, 32'h33331111);
		rd(SEL_WD_HI, 32'h33331111);
		wr(SEL_DR1_HI, 32'h000000ab);
		rd(SEL_DR1, 32'hab11);
		rd(SEL_DR1_LO, 32'h11);
		wr(SEL_WA, 32'h12345678);
		rd(SEL_AR1, 32'h1234);
		rd(SEL_AR0, 32'h5678);
		wr(SEL_FBR, 32'hffffffff);
		rd(SEL_FBR, 32'hffff);
		wr(SEL_SBR, 32'hffffffff);
		rd(SEL_SBR, 32'hffff);
		wr(SEL_VTB, 32'hffffffff);
		rd(SEL_VTB, 32'hfffff);
		wr(SEL_PC, 32'hffffffff);
		@(negedge pclk);
		chk("pc", {12'h0, pc}, 32'hfffff);
		apb(1'b1, 12'h00c, 32'h0000beef);
		rd(SEL_DR3, 32'hbeef);
		wr(SEL_USPTR, 32'h1000);
		wr(SEL_ISPTR, 32'h2000);
		rd(SEL_SP, 32'h2000);
		sf(16'h0090);
		rd(SEL_SP, 32'h1000);
		alu(SZ_WORD, 32'h00010000, 1'b1, 1'b0, 16'h0095);
		alu(SZ_WORD, 32'h00008000, 1'b0, 1'b1, 16'h00b8);
		alu(SZ_LONG, 32'h00010000, 1'b0, 1'b0, 16'h0090);
		alu(SZ_BYTE, 32'h00000080, 1'b0, 1'b0, 16'h0098);
		sf(16'h30c0);
		for (int p = 0; p < 8; p++)
			acc(1'b1, p[2:0], p > 3);
		@(posedge pclk);
		irq_ack <= 1'b1;
		@(posedge pclk);
		irq_ack <= 1'b0;
		fchk(16'h3000);
		acc(1'b1, 3'h7, 1'b0);
		acc(1'b0, 3'h7, 1'b1);
		sf(16'h0080);
		swi(6'h20, 16'h0080);
		swi(6'h1f, 16'h0000);
		sf(16'h0002);
		@(posedge pclk);
		instr_done <= 1'b1;
		@(posedge pclk);
		instr_done <= 1'b0;
		@(negedge pclk);
		chk("step_irq", {31'h0, step_irq}, 32'h1);
		@(posedge pclk);
		step_ack <= 1'b1;
		@(posedge pclk);
		step_ack <= 1'b0;
		fchk(16'h0000);
		chk("step_irq", {31'h0, step_irq}, 32'h0);
		apb(1'b0, 12'h054, 32'h0);
		chk("pslverr", {31'h0, rerr}, 32'h1);
		chk("prdata", rdat, 32'h0);
		apb(1'b1, 12'h046, 32'hffff);
		chk("pslverr", {31'h0, rerr}, 32'h1);
		summarize();
	end
endmodule : cbrf_regfile_test
